// [logic/sft_pkg.sv]
// constants, types and register map of the sdlc frame transmitter
// shared by the design and its bench; no logic here
package sft_pkg;
    // register indices on the plain register port
    localparam logic [2:0] A_CMD = 3'h0;
    localparam logic [2:0] A_RXCFG = 3'h1;
    localparam logic [2:0] A_MODE = 3'h2;
    localparam logic [2:0] A_TXCFG = 3'h3;
    localparam logic [2:0] A_DATA = 3'h4;
    localparam logic [2:0] A_STAT = 3'h5;
    localparam logic [2:0] A_INTCFG = 3'h6;
    // command codes in command_register bits 2:0
    localparam logic [2:0] CMD_ABORT = 3'h1;
    localparam logic [2:0] CMD_RST_EXT = 3'h2;
    localparam logic [2:0] CMD_CHAN_RST = 3'h3;
    localparam logic [2:0] CMD_RST_TXPEND = 3'h5;
    localparam logic [2:0] CMD_RST_CRC = 3'h6;
    localparam logic [2:0] CMD_RST_EOM = 3'h7;
    // status bit positions
    localparam int ST_EMPTY = 0;
    localparam int ST_EOM = 1;
    localparam int ST_TXPEND = 2;
    localparam int ST_EXTPEND = 3;
    // interrupt and wait/ready control bit positions
    localparam int IC_TX_IE = 0;
    localparam int IC_EXT_IE = 1;
    localparam int IC_WR_EN = 2;
    localparam int IC_WR_DMA = 3;
    // line patterns and crc
    localparam logic [7:0] FLAG_PAT = 8'h7e;
    localparam logic [7:0] ABORT_PAT = 8'hff;
    localparam logic [15:0] CRC_POLY_REV = 16'h8408;
    localparam logic [15:0] CRC_PRESET = 16'hffff;
    localparam logic [2:0] STUFF_LIMIT = 3'h5;
    localparam logic [4:0] CHAR_BITS = 5'h08;
    localparam logic [4:0] CRC_BITS = 5'h10;
    localparam logic [7:0] REG_RESET = 8'h00;

    typedef enum logic [4:0] {
        ST_MARK = 5'b00001,
        ST_FLAG = 5'b00010,
        ST_DATA = 5'b00100,
        ST_CRC = 5'b01000,
        ST_ABORT = 5'b10000
    } sft_state_e;

    // transmit_config layout, bit 7 first
    typedef struct packed {
        logic dtr;
        logic [1:0] len;
        logic rsv;
        logic tx_en;
        logic crc_sel;
        logic rts;
        logic crc_en;
    } sft_txcfg_s;

    // length code to bit count: 00 five, 10 six, 01 seven, 11 eight
    function automatic logic [4:0] char_bits(input logic [1:0] code);
        unique case (code)
            2'b00: char_bits = 5'h05;
            2'b10: char_bits = 5'h06;
            2'b01: char_bits = 5'h07;
            default: char_bits = 5'h08;
        endcase
    endfunction : char_bits
endpackage : sft_pkg

// [logic/sft_transmitter.sv]
// sdlc frame transmitter: buffer, shifter, zero insertion, crc, abort
// assumes txc comes from the far side, asynchronous to clk_sys
// Notes on behaviour
// - buffer going full to empty raises transmit interrupt when enabled.
// - data write or reset-pending command clears transmit interrupt pending.
// - no buffer-empty interrupt after enable until first character written.
// - wait toward cpu while buffer full; ready toward dma when empty and transmitter enabled.
// - underrun with end-of-message latch clear sends crc then flags.
// - latch set after reset; underrun with latch set sends flags.
// - host clears latch during frame; device sets it on crc start.
// - during crc, latch shows set and buffer-empty shows clear.
// - after crc and flag load, buffer-empty set and interrupt raised.
// - latch set by underrun raises external/status interrupt.
// - send-abort overrides crc, data or flag immediately.
// - host presets crc to ones; accumulation starts with address.
// - one flag after enable; host waits for more before data.
// - crc enable set before address; crc covers all, sent inverted.
// - disable lets current character finish, then line marks.
// - disable keeps buffer; crc in progress runs 16 bits as flags.
// - characters sent lsb first, short ones right justified.
// - character length taken when moved from buffer to shifter.
// - transmit_config holds dtr, length, enable, crc select, rts, crc enable.
// - receive_config holds receive length and receive controls.
// - line marks when disabled or reset, flags when idle enabled.
// - abort sends eight ones, discards data, then reverts to flags.
// - zero inserted after five ones in data and crc only.
`timescale 1ns/1ps
`default_nettype none
module sft_transmitter (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic txc,
    output logic txd,
    output logic dtr,
    output logic rts,
    output logic tx_int_req,
    output logic ext_int_req,
    output logic cpu_wait,
    output logic dma_ready,
    output logic [7:0] rx_cfg,
    output logic [7:0] mode_cfg
);
    sft_pkg::sft_txcfg_s txcfg_q;
    sft_pkg::sft_state_e st_q, ld_st, sel_st;
    logic [7:0] rxcfg_q, mode_q, intcfg_q, buf_q, rd_q;
    logic [15:0] sh_q, ld_sh, sel_sh, crc_q, crc_nx;
    logic [4:0] bits_q, ld_bits, sel_bits, sent;
    logic [2:0] ones_q;
    logic buf_full_q, eom_q, tx_pend_q, ext_pend_q, abort_req_q, txd_q;
    logic crc_on_q, ld_crc_on, sel_crc_on, txc_m_q, txc_s_q, txc_p_q, tick;
    logic wr_cmd, chan_rst, cmd_abort, stuff, load, go, bit_out, crc_start;
    logic consume, crc_done, seen_wr_q, tx_en;

    assign wr_cmd = reg_wr && reg_addr == sft_pkg::A_CMD;
    assign chan_rst = rst || (wr_cmd && reg_wdata[2:0] == sft_pkg::CMD_CHAN_RST);
    assign cmd_abort = wr_cmd && reg_wdata[2:0] == sft_pkg::CMD_ABORT;
    assign tx_en = txcfg_q.tx_en;

    // txc is foreign: three flops, edge found on the second and third
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txc_m_q <= 1'b1;
            txc_s_q <= 1'b1;
            txc_p_q <= 1'b1;
        end else begin
            txc_m_q <= txc;
            txc_s_q <= txc_m_q;
            txc_p_q <= txc_s_q;
        end
    end
    // line changes on the falling edge so the far side samples mid-bit
    assign tick = txc_p_q && !txc_s_q;

    // stuffing only in data and live crc
    assign stuff = ones_q == sft_pkg::STUFF_LIMIT
        && (st_q == sft_pkg::ST_DATA || (st_q == sft_pkg::ST_CRC && tx_en));
    assign load = bits_q == 5'h00;
    // abort never waits for a character boundary
    assign go = abort_req_q || (load && !stuff);

    // choice of the next character at a boundary
    always_comb begin
        ld_st = sft_pkg::ST_FLAG;
        ld_sh = {8'h00, sft_pkg::FLAG_PAT};
        ld_bits = sft_pkg::CHAR_BITS;
        ld_crc_on = 1'b0;
        if (abort_req_q) begin
            ld_st = sft_pkg::ST_ABORT;
            ld_sh = {8'h00, sft_pkg::ABORT_PAT};
        end else if (!tx_en) begin
            // line marks once the character is done
            ld_st = sft_pkg::ST_MARK;
            ld_bits = 5'h00;
        end else if (buf_full_q) begin
            // length sampled at the move into the shifter
            ld_st = sft_pkg::ST_DATA;
            ld_sh = {8'h00, buf_q};
            ld_bits = sft_pkg::char_bits(txcfg_q.len);
            ld_crc_on = txcfg_q.crc_en;
        end else if (st_q == sft_pkg::ST_DATA && !eom_q) begin
            // underrun closes the frame; crc goes out inverted
            ld_st = sft_pkg::ST_CRC;
            ld_sh = ~crc_q;
            ld_bits = sft_pkg::CRC_BITS;
        end
    end

    assign sel_st = go ? ld_st : st_q;
    assign sel_sh = go ? ld_sh : sh_q;
    assign sel_bits = go ? ld_bits : bits_q;
    assign sel_crc_on = go ? ld_crc_on : crc_on_q;
    assign sent = sft_pkg::CRC_BITS - sel_bits;
    assign crc_start = tick && go && ld_st == sft_pkg::ST_CRC;
    assign consume = tick && go && ld_st == sft_pkg::ST_DATA;
    assign crc_done = tick && go && !abort_req_q && st_q == sft_pkg::ST_CRC;

    always_comb begin
        if (sel_st == sft_pkg::ST_MARK) begin
            bit_out = 1'b1;
        end else if (sel_st == sft_pkg::ST_CRC && !tx_en) begin
            // crc slot still runs its 16 bits, filled with flag bits
            bit_out = sft_pkg::FLAG_PAT[sent[2:0]];
        end else begin
            bit_out = sel_sh[0];
        end
    end

    // reflected ccitt step, data lsb first
    assign crc_nx = (crc_q >> 1) ^ ((crc_q[0] ^ bit_out) ? sft_pkg::CRC_POLY_REV : 16'h0000);

    // shifter and line
    always_ff @(posedge clk_sys) begin
        if (chan_rst) begin
            st_q <= sft_pkg::ST_MARK;
            sh_q <= 16'h0000;
            bits_q <= 5'h00;
            ones_q <= 3'h0;
            crc_on_q <= 1'b0;
            txd_q <= 1'b1;
        end else if (tick && stuff && !abort_req_q) begin
            txd_q <= 1'b0;
            ones_q <= 3'h0;
        end else if (tick) begin
            st_q <= sel_st;
            crc_on_q <= sel_crc_on;
            txd_q <= bit_out;
            if (sel_st == sft_pkg::ST_MARK) begin
                sh_q <= 16'h0000;
                bits_q <= 5'h00;
            end else begin
                sh_q <= sel_sh >> 1;
                bits_q <= sel_bits - 5'h01;
            end
            if (bit_out && (sel_st == sft_pkg::ST_DATA
                    || (sel_st == sft_pkg::ST_CRC && tx_en))) begin
                ones_q <= ones_q + 3'h1;
            end else begin
                ones_q <= 3'h0;
            end
        end
    end
    assign txd = txd_q;

    // crc accumulator
    always_ff @(posedge clk_sys) begin
        if (chan_rst) begin
            crc_q <= sft_pkg::CRC_PRESET;
        end else if (wr_cmd && reg_wdata[2:0] == sft_pkg::CMD_RST_CRC) begin
            crc_q <= sft_pkg::CRC_PRESET;
        end else if (tick && !(stuff && !abort_req_q)
                && sel_st == sft_pkg::ST_DATA && sel_crc_on) begin
            // data characters loaded into the shifter while crc enable was set
            crc_q <= crc_nx;
        end
    end

    // configuration registers and transmit buffer
    always_ff @(posedge clk_sys) begin
        if (chan_rst) begin
            txcfg_q <= sft_pkg::REG_RESET;
            rxcfg_q <= sft_pkg::REG_RESET;
            mode_q <= sft_pkg::REG_RESET;
            intcfg_q <= sft_pkg::REG_RESET;
            buf_q <= sft_pkg::REG_RESET;
            buf_full_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == sft_pkg::A_TXCFG) txcfg_q <= reg_wdata;
            // receive controls kept for the receive side
            if (reg_wr && reg_addr == sft_pkg::A_RXCFG) rxcfg_q <= reg_wdata;
            if (reg_wr && reg_addr == sft_pkg::A_MODE) mode_q <= reg_wdata;
            if (reg_wr && reg_addr == sft_pkg::A_INTCFG) intcfg_q <= reg_wdata;
            if (reg_wr && reg_addr == sft_pkg::A_DATA) begin
                buf_q <= reg_wdata;
                buf_full_q <= 1'b1;
            end else if (cmd_abort) begin
                buf_full_q <= 1'b0;
            end else if (consume) begin
                buf_full_q <= 1'b0;
            end
        end
    end
    assign dtr = txcfg_q.dtr;
    assign rts = txcfg_q.rts;
    assign rx_cfg = rxcfg_q;
    assign mode_cfg = mode_q;

    // status latches; a set in the same cycle as its clear wins
    always_ff @(posedge clk_sys) begin
        if (chan_rst) begin
            eom_q <= 1'b1;
            tx_pend_q <= 1'b0;
            ext_pend_q <= 1'b0;
            abort_req_q <= 1'b0;
            seen_wr_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == sft_pkg::A_DATA) seen_wr_q <= 1'b1;
            // set on crc start, cleared by command
            if (crc_start) begin
                eom_q <= 1'b1;
            end else if (wr_cmd && reg_wdata[2:0] == sft_pkg::CMD_RST_EOM) begin
                eom_q <= 1'b0;
            end
            // emptying raises the pending bit; only a real emptying counts
            if ((consume || crc_done) && intcfg_q[sft_pkg::IC_TX_IE]) begin
                tx_pend_q <= 1'b1;
            end else if ((reg_wr && reg_addr == sft_pkg::A_DATA)
                    || (wr_cmd && reg_wdata[2:0] == sft_pkg::CMD_RST_TXPEND)) begin
                // satisfied by data or the reset-pending command
                tx_pend_q <= 1'b0;
            end
            if (crc_start) begin
                ext_pend_q <= 1'b1;
            end else if (wr_cmd && reg_wdata[2:0] == sft_pkg::CMD_RST_EXT) begin
                ext_pend_q <= 1'b0;
            end
            // request held until the next line edge
            if (cmd_abort) begin
                abort_req_q <= 1'b1;
            end else if (tick) begin
                abort_req_q <= 1'b0;
            end
        end
    end
    assign tx_int_req = tx_pend_q;
    assign ext_int_req = ext_pend_q && intcfg_q[sft_pkg::IC_EXT_IE];

    assign cpu_wait = intcfg_q[sft_pkg::IC_WR_EN] && !intcfg_q[sft_pkg::IC_WR_DMA] && buf_full_q;
    assign dma_ready = intcfg_q[sft_pkg::IC_WR_EN] && intcfg_q[sft_pkg::IC_WR_DMA]
        && !buf_full_q && tx_en;

    // read port, data in the following cycle only
    always_ff @(posedge clk_sys) begin
        if (rst || !reg_rd) begin
            rd_q <= 8'h00;
        end else if (reg_addr == sft_pkg::A_STAT) begin
            rd_q <= 8'h00;
            // crc occupies the register, so not empty
            rd_q[sft_pkg::ST_EMPTY] <= !buf_full_q && st_q != sft_pkg::ST_CRC;
            rd_q[sft_pkg::ST_EOM] <= eom_q;
            rd_q[sft_pkg::ST_TXPEND] <= tx_pend_q;
            rd_q[sft_pkg::ST_EXTPEND] <= ext_pend_q;
        end else begin
            rd_q <= 8'h00;
        end
    end
    assign reg_rdata = rd_q;

    // helper: ones run on the line; marking excluded, it may last forever
    localparam logic [3:0] ABORT_RUN_MIN = 4'h7;
    localparam logic [3:0] ABORT_RUN_MAX = 4'hd;
    logic [3:0] run_q;
    always_ff @(posedge clk_sys) begin
        if (chan_rst || st_q == sft_pkg::ST_MARK) begin
            run_q <= 4'h0;
        end else if (tick && !txd_q) begin
            run_q <= 4'h0;
        end else if (tick && run_q != 4'hf) begin
            run_q <= run_q + 4'h1;
        end
    end

    eom_after_reset_a: assert property (@(posedge clk_sys) !rst && $past(chan_rst) |-> eom_q)
        else $error("latch not set after reset");
    crc_status_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_q == sft_pkg::ST_CRC && reg_rd && reg_addr == sft_pkg::A_STAT
        |=> reg_rdata[sft_pkg::ST_EOM] && !reg_rdata[sft_pkg::ST_EMPTY])
        else $error("crc status wrong");
    mark_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_q == sft_pkg::ST_MARK |-> txd_q)
        else $error("line not marking");
    abort_start_a: assert property (@(posedge clk_sys) disable iff (rst)
        cmd_abort && !chan_rst |-> ##[1:14] st_q == sft_pkg::ST_ABORT)
        else $error("abort not started");
    first_int_a: assert property (@(posedge clk_sys) disable iff (rst)
        !seen_wr_q |-> !tx_pend_q)
        else $error("interrupt before first write");
    stuff_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
        tick && stuff && !abort_req_q |=> !txd_q)
        else $error("zero not inserted");
    ext_on_crc_a: assert property (@(posedge clk_sys) disable iff (chan_rst)
        crc_start |=> ext_pend_q && eom_q)
        else $error("underrun status missing");
    pend_clear_a: assert property (@(posedge clk_sys) disable iff (chan_rst)
        wr_cmd && reg_wdata[2:0] == sft_pkg::CMD_RST_TXPEND && !consume && !crc_done
        |=> !tx_pend_q)
        else $error("pending not cleared");
    tx_int_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(tx_pend_q) |-> $past(consume || crc_done))
        else $error("interrupt without emptying");
    crc_frame_c: cover property (@(posedge clk_sys) disable iff (rst) crc_done);
    abort_c: cover property (@(posedge clk_sys) disable iff (rst)
        tick && abort_req_q && st_q == sft_pkg::ST_DATA);
    flag_fill_c: cover property (@(posedge clk_sys) disable iff (rst)
        tick && load && eom_q && st_q == sft_pkg::ST_DATA && !buf_full_q && tx_en);
    abort_run_a: assert property (@(posedge clk_sys) disable iff (rst)
        run_q <= ABORT_RUN_MAX)
        else $error("too many ones on the line");
    abort_len_a: assert property (@(posedge clk_sys) disable iff (rst)
        tick && load && st_q == sft_pkg::ST_ABORT |-> run_q >= ABORT_RUN_MIN && txd_q)
        else $error("abort too short");
    crc_end_a: assert property (@(posedge clk_sys) disable iff (chan_rst)
        crc_done && intcfg_q[sft_pkg::IC_TX_IE] |=> tx_pend_q)
        else $error("no interrupt after crc");
    disable_mark_a: assert property (@(posedge clk_sys) disable iff (rst)
        tick && load && !stuff && !abort_req_q && !tx_en |=> st_q == sft_pkg::ST_MARK)
        else $error("line not marking after disable");
    short_char_c: cover property (@(posedge clk_sys) disable iff (rst)
        consume && txcfg_q.len == 2'b00);
    crc_as_flag_c: cover property (@(posedge clk_sys) disable iff (rst)
        tick && st_q == sft_pkg::ST_CRC && !tx_en);
endmodule : sft_transmitter
`default_nettype wire

// [test/sft_far_rx.sv]
// far-side receiver model: makes txc, samples txd, strips stuffed zeros
// assumes txd settles long before the txc rising edge
`timescale 1ns/1ps
`default_nettype none
module sft_far_rx (
    output logic txc,
    input wire logic txd,
    output logic [4:0] raw_run,
    output logic [47:0] dhist
);
    logic [2:0] ones;
    initial begin
        txc = 1'b1;
        raw_run = 5'h00;
        dhist = 48'h0;
        ones = 3'h0;
    end
    // link clock runs free: the line idles with flags or marking
    always #200 txc = ~txc;
    always @(posedge txc) begin
        raw_run <= txd ? ((raw_run == 5'h1f) ? raw_run : raw_run + 5'h01) : 5'h00;
        if (ones == 3'h5 && !txd) begin
            ones <= 3'h0;
        end else begin
            dhist <= {txd, dhist[47:1]};
            ones <= txd ? ((ones == 3'h7) ? ones : ones + 3'h1) : 3'h0;
        end
    end
endmodule : sft_far_rx
`default_nettype wire

// [test/sft_transmitter_tb_top.sv]
// self-checking bench for the sdlc frame transmitter
// assumes the far-side model makes txc at 400 ns and destuffs the line
`timescale 1ns/1ps
`default_nettype none
module sft_transmitter_tb_top;
    localparam int T = 4000;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [7:0] reg_rdata;
    wire [7:0] rx_cfg;
    wire [7:0] mode_cfg;
    wire txc, txd, dtr, rts, tx_int_req, ext_int_req, cpu_wait, dma_ready;
    wire [4:0] raw_run;
    wire [47:0] dhist;
    int mismatches = 0;
    int n_tests = 0;
    int i;
    logic [7:0] st;
    logic [15:0] crc;
    logic [4:0] peak;
    // rows: address, data, then expected dtr, rts, rx_cfg, mode_cfg
    logic [28:0] rows [6] = '{
        {sft_pkg::A_TXCFG, 8'h82, 2'b11, 16'h0000},
        {sft_pkg::A_TXCFG, 8'h80, 2'b10, 16'h0000},
        {sft_pkg::A_TXCFG, 8'h02, 2'b01, 16'h0000},
        {sft_pkg::A_RXCFG, 8'hc1, 2'b01, 16'hc100},
        {sft_pkg::A_MODE, 8'h20, 2'b01, 16'hc120},
        {sft_pkg::A_TXCFG, 8'h00, 2'b00, 16'hc120}};

    sft_transmitter u_sft_transmitter (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .txc(txc), .txd(txd), .dtr(dtr), .rts(rts), .tx_int_req(tx_int_req),
        .ext_int_req(ext_int_req), .cpu_wait(cpu_wait), .dma_ready(dma_ready),
        .rx_cfg(rx_cfg), .mode_cfg(mode_cfg));
    sft_far_rx u_sft_far_rx (.txc(txc), .txd(txd), .raw_run(raw_run), .dhist(dhist));

    always #25 clk_sys = ~clk_sys;

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // a used-up wait bound ends the run
    task automatic tmo(input int n);
        if (n >= T) begin
            mismatches++;
            $display("mismatch at %0t: wait bound used up", $time);
            report_and_stop();
        end
    endtask : tmo

    // lsb-first crc, polynomial given reflected
    function automatic logic [15:0] crc_next(input logic [15:0] c, input logic [7:0] b);
        for (int k = 0; k < 8; k++) begin
            c = (c[0] ^ b[k]) ? ((c >> 1) ^ sft_pkg::CRC_POLY_REV) : (c >> 1);
        end
        return c;
    endfunction : crc_next

    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        chk(txd, 1, "line not marking");
        chk({dtr, rts, tx_int_req, ext_int_req}, 0, "outputs after reset");
        rd(sft_pkg::A_STAT, st);
        chk(st[sft_pkg::ST_EOM], 1, "eom after reset");
        rd(3'h7, st);
        chk(st, 0, "unmapped read");
        $display("test reset done");
        foreach (rows[k]) begin
            wr(rows[k][28:26], rows[k][25:18]);
            @(negedge clk_sys);
            chk({dtr, rts, rx_cfg, mode_cfg}, rows[k][17:0], "config row");
        end
        rd(sft_pkg::A_TXCFG, st);
        chk(st, 0, "write-only read");
        repeat (200) @(posedge clk_sys);
        chk(raw_run >= 16, 1, "disabled line");
        $display("test config done");
        wr(sft_pkg::A_INTCFG, 8'h03);
        wr(sft_pkg::A_TXCFG, 8'h6b);
        for (i = 0; i < T && dhist[47:32] !== 16'h7e7e; i++) @(posedge clk_sys);
        tmo(i);
        chk(tx_int_req, 0, "empty irq before data");
        wr(sft_pkg::A_CMD, {5'h00, sft_pkg::CMD_RST_CRC});
        wr(sft_pkg::A_DATA, 8'h3f);
        wr(sft_pkg::A_CMD, {5'h00, sft_pkg::CMD_RST_EOM});
        for (i = 0; i < T && tx_int_req !== 1'b1; i++) @(posedge clk_sys);
        tmo(i);
        wr(sft_pkg::A_DATA, 8'h81);
        @(negedge clk_sys);
        chk(tx_int_req, 0, "write clears irq");
        for (i = 0; i < T && tx_int_req !== 1'b1; i++) @(posedge clk_sys);
        tmo(i);
        wr(sft_pkg::A_CMD, {5'h00, sft_pkg::CMD_RST_TXPEND});
        @(negedge clk_sys);
        chk(tx_int_req, 0, "command clears irq");
        for (i = 0; i < T; i++) begin
            rd(sft_pkg::A_STAT, st);
            if (st[sft_pkg::ST_EOM]) break;
        end
        tmo(i);
        chk(st[sft_pkg::ST_EMPTY], 0, "empty during crc");
        for (i = 0; i < T && ext_int_req !== 1'b1; i++) @(posedge clk_sys);
        tmo(i);
        for (i = 0; i < T && tx_int_req !== 1'b1; i++) @(posedge clk_sys);
        tmo(i);
        rd(sft_pkg::A_STAT, st);
        chk(st[sft_pkg::ST_EMPTY], 1, "empty after crc");
        crc = crc_next(crc_next(sft_pkg::CRC_PRESET, 8'h3f), 8'h81);
        for (i = 0; i < T
                && dhist !== {sft_pkg::FLAG_PAT, ~crc, 16'h813f, sft_pkg::FLAG_PAT}; i++) begin
            @(posedge clk_sys);
        end
        tmo(i);
        wr(sft_pkg::A_CMD, {5'h00, sft_pkg::CMD_RST_EXT});
        wr(sft_pkg::A_CMD, {5'h00, sft_pkg::CMD_RST_TXPEND});
        @(negedge clk_sys);
        chk({ext_int_req, tx_int_req}, 0, "pending cleared");
        $display("test frame done");
        wr(sft_pkg::A_INTCFG, 8'h0c);
        @(negedge clk_sys);
        chk(dma_ready, 1, "ready when empty");
        wr(sft_pkg::A_DATA, 8'h11);
        @(negedge clk_sys);
        chk(dma_ready, 0, "ready when full");
        for (i = 0; i < T && dma_ready !== 1'b1; i++) @(posedge clk_sys);
        tmo(i);
        wr(sft_pkg::A_INTCFG, 8'h04);
        wr(sft_pkg::A_DATA, 8'h22);
        @(negedge clk_sys);
        chk(cpu_wait, 1, "wait when full");
        for (i = 0; i < T && dhist[47:32] !== 16'h7e22; i++) @(posedge clk_sys);
        tmo(i);
        $display("test handshake done");
        wr(sft_pkg::A_DATA, 8'h55);
        for (i = 0; i < T && cpu_wait !== 1'b0; i++) @(posedge clk_sys);
        tmo(i);
        wr(sft_pkg::A_DATA, 8'h66);
        @(negedge clk_sys);
        chk(cpu_wait, 1, "second byte held");
        wr(sft_pkg::A_CMD, {5'h00, sft_pkg::CMD_ABORT});
        @(negedge clk_sys);
        chk(cpu_wait, 0, "second byte lost");
        peak = 5'h00;
        repeat (1200) begin
            @(posedge clk_sys);
            if (raw_run > peak) peak = raw_run;
        end
        chk(peak >= 8 && peak < 14, 1, "abort ones");
        rd(sft_pkg::A_STAT, st);
        chk(st[sft_pkg::ST_EMPTY], 1, "buffer dropped");
        for (i = 0; i < T && dhist[47:40] !== sft_pkg::FLAG_PAT; i++) @(posedge clk_sys);
        tmo(i);
        $display("test abort done");
        wr(sft_pkg::A_CMD, {5'h00, sft_pkg::CMD_CHAN_RST});
        @(negedge clk_sys);
        chk({dtr, rts, rx_cfg, mode_cfg, txd}, 19'h00001, "channel reset outputs");
        rd(sft_pkg::A_STAT, st);
        chk(st, 8'h03, "channel reset status");
        repeat (200) @(posedge clk_sys);
        chk(raw_run >= 16, 1, "marking after channel reset");
        $display("test channel reset done");
        wr(sft_pkg::A_TXCFG, 8'h0b);
        for (i = 0; i < T && dhist[47:32] !== 16'h7e7e; i++) @(posedge clk_sys);
        tmo(i);
        wr(sft_pkg::A_DATA, 8'hea);
        for (i = 0; i < T
                && dhist[47:27] !== {sft_pkg::FLAG_PAT, 5'h0a, sft_pkg::FLAG_PAT}; i++) begin
            @(posedge clk_sys);
        end
        tmo(i);
        $display("test short character done");
        wr(sft_pkg::A_TXCFG, 8'h63);
        repeat (400) @(posedge clk_sys);
        chk(raw_run >= 16, 1, "marking after disable");
        $display("test disable done");
        report_and_stop();
    end
endmodule : sft_transmitter_tb_top
`default_nettype wire
